// ===== design/sram_rd_pkg.sv
// Constants shared by the error-checked memory read controller.
// How it works
// [R1] Memory raises the error flag on a detected error of configured class.
// [R2] In scrub mode the flag floats with output enable high, reports when low.
// [R3] Clearing: deselect the memory first, then raise output enable.
// [R4] Raising the active-low select during clearing pauses scrubbing.
// [R5] While deselected, wait for flag low and move to last good address.
// [R6] Re-enable with output enable high, then lower it to read good address.
// [R7] After clearing, the memory drives the flag low on each read.
// [R8] Enabled with output enable high, the memory floats the flag.
// [R9] Read needs select low, select high, write high; data only with oe low.
// [R10] Access time counts from the last of enable, oe or valid address.
// [R11] Address-controlled read: data within 20 ns; changes 20 ns apart.
// [R12] Old data and flag are held 7.5 ns after an address change.
// [R13] Enable-controlled read: word valid 20 ns after the later enable.
// [R14] Output-enable-controlled read: data within 8.6 ns of oe falling; the memory model gives it 20 ns after.
// [R15] Data bus released 3.5 to 5 ns after output enable rises; the memory model changes dq_in 20 ns after.
// [R16] Address-controlled read: flag valid within 20 ns of address change.
// [R17] Flag low means valid data, high means corrupt; class set by A[12].
// [R18] Write enable low with both selects active is a word write.
// [R19] Enabled, oe and we high: flag high selects function, else tri-state.
// [R20] Flag valid within 8.6 ns of output enable falling.
// [R21] Sample the flag after its valid delay; start clearing when high.
package sram_rd_pkg;
   localparam int CLK_PERIOD_PS = 100000;
   localparam int T_ADDR_VALID_PS = 20000;
   localparam int T_OE_VALID_PS = 8600;
   localparam int T_OE_RELEASE_PS = 5000;
   localparam int T_FLAG_FALL_PS = 1000000;
   // Least times round up to whole cycles, never under one.
   function automatic int cyc_up(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up
   localparam int ADDR_VALID_CYC = cyc_up(T_ADDR_VALID_PS);
   localparam int OE_VALID_CYC = cyc_up(T_OE_VALID_PS);
   localparam int OE_RELEASE_CYC = cyc_up(T_OE_RELEASE_PS);
   localparam int FLAG_FALL_CYC = cyc_up(T_FLAG_FALL_PS);
   localparam int ADDR_W = 19;
   localparam int DATA_W = 32;
   localparam int CNT_W = 8;
endpackage : sram_rd_pkg

// ===== design/sync2.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
module sync2
#(
   parameter int W = 1
)
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Pin side and synchronised side.
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] sync_out
);
   // A zero-width chain has nothing to synchronise.
   if (W < 1)
   begin : g_w_check
      $error("Synchroniser width must be at least one.");
   end
   logic [W-1:0] meta_r;
   // The first stage feeds only the second stage.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else if (clk_en)
      begin
         meta_r <= pin_in;
         sync_out <= meta_r;
      end
   end
endmodule : sync2

// ===== design/sram_rd_ctrl.sv
// Read controller for an error-checked asynchronous memory, with flag clear.
`timescale 1ns/100ps
module sram_rd_ctrl
   import sram_rd_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // User read request and answer.
   input wire logic rd_req,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic rd_busy,
   output logic rd_done,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_err,
   output logic clear_done,
   // Address of the last word read without error.
   output logic [ADDR_W-1:0] good_addr,
   // Memory pins.
   output logic select_low_n,
   output logic select_high,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic error_flag
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ACCESS, ST_RELEASE, ST_DESEL, ST_ADDR_FIX, ST_REEN,
      ST_GOOD_RD
   } state_t;
   typedef struct packed {
      state_t st;
      logic [CNT_W-1:0] cnt;
      logic sel_n;
      logic sel_h;
      logic oe_n;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] good;
      logic [DATA_W-1:0] data;
      logic err;
      logic done;
      logic cdone;
   } regs_t;
   regs_t s_r;
   regs_t s_nxt;
   logic [DATA_W-1:0] dq_s;
   logic flag_s;
   // Memory pins are asynchronous to sys_clk, so both pass two flops.
   sync2 #(.W(DATA_W + 1)) u_sync
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .pin_in({error_flag, dq_in}),
      .sync_out({flag_s, dq_s})
   );
   // Sampling delay covers the access time plus the two synchroniser stages.
   localparam logic [CNT_W-1:0] ACC_WAIT = CNT_W'(ADDR_VALID_CYC + 2);
   localparam logic [CNT_W-1:0] OE_WAIT = CNT_W'(OE_VALID_CYC + 2);
   localparam logic [CNT_W-1:0] REL_WAIT = CNT_W'(OE_RELEASE_CYC);
   localparam logic [CNT_W-1:0] FALL_WAIT = CNT_W'(FLAG_FALL_CYC + 2);
   // A fall wait that wraps the counter would re-enable the memory early.
   if (FLAG_FALL_CYC + 2 >= (1 << CNT_W))
   begin : g_cnt_check
      $error("Flag fall time does not fit the counter.");
   end
   // Next-state logic for the read and flag-clearing sequence.
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.cdone = 1'b0;
      if (s_r.cnt != '0)
         s_nxt.cnt = s_r.cnt - CNT_W'(1);
      unique case (s_r.st)
         ST_IDLE:
         begin
            if (rd_req)
            begin
               // Select, write high and oe low form a read. // [R9]
               s_nxt.addr = rd_addr;
               s_nxt.sel_n = 1'b0;
               s_nxt.sel_h = 1'b1;
               s_nxt.oe_n = 1'b0;
               s_nxt.cnt = ACC_WAIT; // [R10] [R11] [R13] [R16]
               s_nxt.st = ST_ACCESS;
            end
         end
         ST_ACCESS:
         begin
            if (s_r.cnt == '0)
            begin
               s_nxt.data = dq_s;
               s_nxt.err = flag_s; // [R17] [R21]
               s_nxt.done = 1'b1;
               if (flag_s)
               begin
                  // Deselect before raising output enable. // [R3] [R4]
                  s_nxt.sel_n = 1'b1;
                  s_nxt.sel_h = 1'b0;
                  s_nxt.st = ST_DESEL;
               end
               else
               begin
                  s_nxt.good = s_r.addr;
                  s_nxt.oe_n = 1'b1;
                  s_nxt.cnt = REL_WAIT; // [R15]
                  s_nxt.st = ST_RELEASE;
               end
            end
         end
         ST_RELEASE:
         begin
            if (s_r.cnt == '0)
            begin
               s_nxt.sel_n = 1'b1;
               s_nxt.sel_h = 1'b0;
               s_nxt.st = ST_IDLE;
            end
         end
         ST_DESEL:
         begin
            // Now raise oe while deselected so the load resistor drops it.
            s_nxt.oe_n = 1'b1; // [R3]
            s_nxt.addr = s_r.good; // [R5]
            s_nxt.cnt = FALL_WAIT;
            s_nxt.st = ST_ADDR_FIX;
         end
         ST_ADDR_FIX:
         begin
            // Wait out the fall time and a low flag before re-enabling. // [R5]
            if (s_r.cnt == '0 && !flag_s)
            begin
               s_nxt.sel_n = 1'b0; // [R6]
               s_nxt.sel_h = 1'b1;
               s_nxt.cnt = REL_WAIT;
               s_nxt.st = ST_REEN;
            end
         end
         ST_REEN:
         begin
            // Oe stays high here, so the memory leaves the flag floating. // [R8]
            if (s_r.cnt == '0)
            begin
               s_nxt.oe_n = 1'b0; // [R6] [R14] [R20]
               s_nxt.cnt = OE_WAIT;
               s_nxt.st = ST_GOOD_RD;
            end
         end
         ST_GOOD_RD:
         begin
            if (s_r.cnt == '0)
            begin
               // A still-high flag restarts clearing; low means done. // [R7]
               if (flag_s)
               begin
                  s_nxt.sel_n = 1'b1;
                  s_nxt.sel_h = 1'b0;
                  s_nxt.st = ST_DESEL;
               end
               else
               begin
                  s_nxt.cdone = 1'b1;
                  s_nxt.oe_n = 1'b1;
                  s_nxt.cnt = REL_WAIT;
                  s_nxt.st = ST_RELEASE;
               end
            end
         end
      endcase
   end
   // All state registers; the clock enable freezes everything.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_r <= '{st: ST_IDLE, cnt: '0, sel_n: 1'b1, sel_h: 1'b0,
                  oe_n: 1'b1, addr: '0, good: '0, data: '0, err: 1'b0,
                  done: 1'b0, cdone: 1'b0};
      end
      else if (clk_en)
      begin
         s_r <= s_nxt;
      end
   end
   // Pin and user outputs; this controller never writes, so dq is not driven.
   assign select_low_n = s_r.sel_n;
   assign select_high = s_r.sel_h;
   assign output_enable_n = s_r.oe_n;
   assign write_enable_n = 1'b1; // [R18] [R19]
   assign mem_addr = s_r.addr;
   assign dq_out = '0;
   assign dq_oe = 1'b0;
   assign rd_busy = (s_r.st != ST_IDLE);
   assign rd_done = s_r.done;
   assign rd_data = s_r.data;
   assign rd_err = s_r.err;
   assign clear_done = s_r.cdone;
   assign good_addr = s_r.good;

   // A frozen clock enable holds the state, so only enabled edges count.
   a_oe_after_desel: assert property ( // [R3]
      @(posedge sys_clk) disable iff (!nrst)
      (clk_en && s_r.st == ST_DESEL) |=> s_r.sel_n && s_r.oe_n)
      else $error("Output enable rose before deselect.");
   a_addr_good: assert property ( // [R5]
      @(posedge sys_clk) disable iff (!nrst)
      (s_r.st == ST_REEN) |-> (s_r.addr == s_r.good))
      else $error("Clearing read not at good address.");
   a_reen_oe_high: assert property ( // [R6]
      @(posedge sys_clk) disable iff (!nrst)
      $rose(s_r.st == ST_REEN) |-> s_r.oe_n && !s_r.sel_n)
      else $error("Re-enable with output enable low.");
   a_read_select: assert property ( // [R9]
      @(posedge sys_clk) disable iff (!nrst)
      !s_r.oe_n |-> !s_r.sel_n || s_r.st == ST_DESEL)
      else $error("Output enable low outside a read.");
   a_addr_spacing: assert property ( // [R11]
      @(posedge sys_clk) disable iff (!nrst)
      $changed(s_r.addr) |=> $stable(s_r.addr))
      else $error("Address changed too soon.");
   a_no_write: assert property ( // [R18]
      @(posedge sys_clk) disable iff (!nrst)
      write_enable_n && !dq_oe)
      else $error("Controller attempted a write.");
   a_flag_starts: assert property ( // [R21]
      @(posedge sys_clk) disable iff (!nrst)
      (clk_en && s_r.st == ST_ACCESS && s_r.cnt == '0 && flag_s)
      |=> s_r.st == ST_DESEL)
      else $error("High flag did not start clearing.");
   a_rel_wait: assert property ( // [R15]
      @(posedge sys_clk) disable iff (!nrst)
      $rose(s_r.oe_n) && s_r.st == ST_RELEASE |-> !s_r.sel_n)
      else $error("Deselected before the bus was released.");
   c_clean_read: cover property (@(posedge sys_clk) disable iff (!nrst)
      s_r.done && !s_r.err);
   c_error_read: cover property (@(posedge sys_clk) disable iff (!nrst)
      s_r.done && s_r.err);
   c_cleared: cover property (@(posedge sys_clk) disable iff (!nrst)
      s_r.cdone);
endmodule : sram_rd_ctrl

// ===== verif/err_mem_model.sv
// Pin-level model of the error-checked asynchronous memory.
`timescale 1ns/100ps
module err_mem_model
   import sram_rd_pkg::*;
(
   // Memory pins.
   input wire logic select_low_n,
   input wire logic select_high,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic [ADDR_W-1:0] mem_addr,
   output logic [DATA_W-1:0] dq_in,
   output logic error_flag,
   // Location that reads back as faulty.
   input wire logic [ADDR_W-1:0] bad_addr
);
   logic sel;
   logic rd;
   logic [DATA_W-1:0] word;
   logic flag_r = 1'b0;
   // A read needs both selects active and write enable high.
   // Deselecting would also pause scrubbing, which this model never runs.
   assign sel = !select_low_n && select_high;
   assign rd = sel && write_enable_n && !output_enable_n;
   assign word = {mem_addr[15:0], ~mem_addr[15:0]};
   // A released bus shows the inverse word so stale data cannot pass.
   assign #20 dq_in = rd ? word : ~word;
   // Each read sets or clears the error latch by its address.
   always @(mem_addr or rd)
      if (rd)
         flag_r = (mem_addr == bad_addr);
   // A set latch keeps the flag high while oe is low, even when deselected,
   // so only raising oe lets the pull-down take it low.
   assign #8 error_flag = flag_r && !output_enable_n;
endmodule : err_mem_model

// ===== verif/tb.sv
// Self-checking bench for the memory read controller.
`timescale 1ns/100ps
module tb
   import sram_rd_pkg::*;
();
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic rd_req = 1'b0;
   logic [ADDR_W-1:0] rd_addr = '0;
   logic [ADDR_W-1:0] bad_addr = 19'h7FFFF;
   logic rd_busy, rd_done, rd_err, clear_done, error_flag;
   logic select_low_n, select_high, output_enable_n, write_enable_n;
   logic [DATA_W-1:0] rd_data, dq_in;
   logic [DATA_W-1:0] dq_out;
   logic dq_oe;
   logic [ADDR_W-1:0] good_addr, mem_addr;
   logic in_clr = 1'b0;
   logic oe_n_q = 1'b1;
   logic sel_q = 1'b0;
   logic sel_now;
   int num_errors = 0;
   int comparisons = 0;
   // Clock at 100 ns period.
   initial forever #50 sys_clk = ~sys_clk;
   assign sel_now = !select_low_n && select_high;
   sram_rd_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_busy(rd_busy),
      .rd_done(rd_done), .rd_data(rd_data), .rd_err(rd_err),
      .clear_done(clear_done), .good_addr(good_addr),
      .select_low_n(select_low_n), .select_high(select_high),
      .output_enable_n(output_enable_n),
      .write_enable_n(write_enable_n), .mem_addr(mem_addr),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .error_flag(error_flag));
   err_mem_model mem (.select_low_n(select_low_n),
      .select_high(select_high), .output_enable_n(output_enable_n),
      .write_enable_n(write_enable_n), .mem_addr(mem_addr),
      .dq_in(dq_in), .error_flag(error_flag), .bad_addr(bad_addr));
   task automatic chk(input string name, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", name, e, g);
         num_errors++;
      end
   endtask : chk
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   // Bounded wait for a flag; running out ends the run.
   task automatic wait_hi(ref logic s, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge sys_clk);
         if (s === 1'b1)
            return;
      end
      num_errors++;
      end_of_test();
   endtask : wait_hi
   task automatic do_read(input logic [ADDR_W-1:0] a);
      @(negedge sys_clk);
      rd_req = 1'b1;
      rd_addr = a;
      @(negedge sys_clk);
      rd_req = 1'b0;
   endtask : do_read
   // The clearing sequence is watched at each falling edge, where the pins
   // have settled since the rising edge that moved them.
   // The oe rise that ends the final good read is not a clearing step.
   always @(negedge sys_clk)
   begin
      if (in_clr && !clear_done && output_enable_n && !oe_n_q)
         chk("sel at oe rise", 32'h0, {31'h0, sel_now});
      if (in_clr && sel_now && !sel_q)
      begin
         chk("addr reselect", {13'h0, good_addr}, {13'h0, mem_addr});
         chk("flag reselect", 32'h0, {31'h0, error_flag});
      end
      in_clr <= (rd_done && rd_err) ? 1'b1 : (clear_done ? 1'b0 : in_clr);
      oe_n_q <= output_enable_n;
      sel_q <= sel_now;
   end
   // Plain read gives the word and a clear flag.
   task automatic t_good(input logic [ADDR_W-1:0] a);
      do_read(a);
      wait_hi(rd_done, 40);
      chk("data", {a[15:0], ~a[15:0]}, rd_data);
      chk("err", 32'h0, {31'h0, rd_err});
      chk("good addr", {13'h0, a}, {13'h0, good_addr});
      wait_hi(sel_q, 1);
   endtask : t_good
   // Faulty read flags the error, then runs the clearing sequence.
   task automatic t_bad;
      bad_addr = 19'h00456;
      do_read(19'h00456);
      wait_hi(rd_done, 40);
      chk("err bad", 32'h1, {31'h0, rd_err});
      wait_hi(clear_done, 300);
      chk("good kept", 32'h123, {13'h0, good_addr});
      repeat (4) @(negedge sys_clk);
      chk("sel idle", 32'h0, {31'h0, sel_now});
   endtask : t_bad
   // A request while busy is ignored.
   task automatic t_busy;
      do_read(19'h00AAA);
      do_read(19'h00BBB);
      wait_hi(rd_done, 40);
      chk("busy data", 32'h0AAAF555, rd_data);
      repeat (10) @(negedge sys_clk);
      chk("busy idle", 32'h0, {31'h0, rd_busy});
   endtask : t_busy
   // A low clock enable mid-read freezes the controller with pins held.
   task automatic t_freeze(input logic [ADDR_W-1:0] a);
      do_read(a);
      clk_en = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk("frozen busy", 32'h1, {31'h0, rd_busy});
      chk("frozen sel", 32'h1, {31'h0, sel_now});
      chk("frozen done", 32'h0, {31'h0, rd_done});
      clk_en = 1'b1;
      wait_hi(rd_done, 40);
      chk("frozen data", {a[15:0], ~a[15:0]}, rd_data);
      chk("we high", 32'h1, {31'h0, write_enable_n});
      chk("dq oe", 32'h0, {31'h0, dq_oe});
      chk("dq out", 32'h0, dq_out);
   endtask : t_freeze
   initial
   begin
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      t_good(19'h00123);
      t_bad();
      t_good(19'h00789);
      t_busy();
      t_freeze(19'h00321);
      end_of_test();
   end
endmodule : tb
